/* File: rtl/gpx_pkg.sv */
// Purpose: Shared constants and types for the 8-bit serial port expander.
// Assumes: All users reference names as gpx_pkg::name.
// Notes:   Pointer values double as register offsets.

package gpx_pkg;

    localparam logic [7:0] PTR_IN   = 8'h00;
    localparam logic [7:0] PTR_OUT  = 8'h01;
    localparam logic [7:0] PTR_INV  = 8'h02;
    localparam logic [7:0] PTR_DIR  = 8'h03;
    localparam logic [7:0] PTR_DSL  = 8'h40;
    localparam logic [7:0] PTR_DSH  = 8'h41;
    localparam logic [7:0] PTR_LAT  = 8'h42;
    localparam logic [7:0] PTR_PEN  = 8'h43;
    localparam logic [7:0] PTR_PSEL = 8'h44;
    localparam logic [7:0] PTR_MASK = 8'h45;
    localparam logic [7:0] PTR_SRC  = 8'h46;
    localparam logic [7:0] PTR_OSTG = 8'h4F;

    localparam logic [7:0] RST_OUT  = 8'hFF;
    localparam logic [7:0] RST_INV  = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'hFF;
    localparam logic [7:0] RST_DS   = 8'hFF;
    localparam logic [7:0] RST_LAT  = 8'h00;
    localparam logic [7:0] RST_PEN  = 8'h00;
    localparam logic [7:0] RST_PSEL = 8'hFF;
    localparam logic [7:0] RST_MASK = 8'hFF;
    localparam logic [7:0] RST_OSTG = 8'h00;

    localparam logic [4:0] ADDR_FIXED = 5'h1C;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam int         OSTG_OD    = 0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK,
        ST_WAIT
    } gpx_bus_e;

endpackage

/* File: rtl/gpx_reg_if.sv */
// Purpose: Carries register access and configuration between modules.
// Assumes: One core drives access, one register store answers.
// Notes:   Configuration bytes come straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none

interface gpx_reg_if;
    logic       wr;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] outl;
    logic [7:0] inv;
    logic [7:0] dir;
    logic [7:0] dsl;
    logic [7:0] dsh;
    logic [7:0] lat;
    logic [7:0] pen;
    logic [7:0] psel;
    logic [7:0] mask;
    logic [7:0] ostg;

    modport core (output wr, ptr, wdata,
                  input rdata, outl, inv, dir, dsl, dsh, lat, pen, psel,
                  mask, ostg);
    modport regs (input wr, ptr, wdata,
                  output rdata, outl, inv, dir, dsl, dsh, lat, pen, psel,
                  mask, ostg);
endinterface

`default_nettype wire

/* File: rtl/gpx_cfg_regs.sv */
// Purpose: Holds the writable configuration bytes and read data.
// Assumes: Pointer and write strobe come from the bus core.
// Notes:   Input and status bytes are supplied by the core.
`timescale 1ns/1ps
`default_nettype none

module gpx_cfg_regs (
    input  wire logic core_clk_in, // Core clock.
    input  wire logic rst_in,      // Synchronous reset, active high.
    gpx_reg_if.regs   bus          // Register access from the core.
);
    typedef struct packed {
        logic [7:0] outl;
        logic [7:0] inv;
        logic [7:0] dir;
        logic [7:0] dsl;
        logic [7:0] dsh;
        logic [7:0] lat;
        logic [7:0] pen;
        logic [7:0] psel;
        logic [7:0] mask;
        logic [7:0] ostg;
        logic [7:0] rdata;
    } gpx_cfg_s;

    gpx_cfg_s r;
    gpx_cfg_s next_r;

    always_comb begin
        next_r = r;
        if (bus.wr) begin
            case (bus.ptr)
                gpx_pkg::PTR_OUT:  next_r.outl = bus.wdata;
                gpx_pkg::PTR_INV:  next_r.inv  = bus.wdata;
                gpx_pkg::PTR_DIR:  next_r.dir  = bus.wdata;
                gpx_pkg::PTR_DSL:  next_r.dsl  = bus.wdata;
                gpx_pkg::PTR_DSH:  next_r.dsh  = bus.wdata;
                gpx_pkg::PTR_LAT:  next_r.lat  = bus.wdata;
                gpx_pkg::PTR_PEN:  next_r.pen  = bus.wdata;
                gpx_pkg::PTR_PSEL: next_r.psel = bus.wdata;
                gpx_pkg::PTR_MASK: next_r.mask = bus.wdata;
                gpx_pkg::PTR_OSTG: next_r.ostg = {7'h00, bus.wdata[0]};
                default: next_r.rdata = r.rdata;
            endcase
        end
        case (bus.ptr)
            gpx_pkg::PTR_OUT:  next_r.rdata = r.outl;
            gpx_pkg::PTR_INV:  next_r.rdata = r.inv;
            gpx_pkg::PTR_DIR:  next_r.rdata = r.dir;
            gpx_pkg::PTR_DSL:  next_r.rdata = r.dsl;
            gpx_pkg::PTR_DSH:  next_r.rdata = r.dsh;
            gpx_pkg::PTR_LAT:  next_r.rdata = r.lat;
            gpx_pkg::PTR_PEN:  next_r.rdata = r.pen;
            gpx_pkg::PTR_PSEL: next_r.rdata = r.psel;
            gpx_pkg::PTR_MASK: next_r.rdata = r.mask;
            gpx_pkg::PTR_OSTG: next_r.rdata = r.ostg;
            default:           next_r.rdata = 8'h00;
        endcase
        if (rst_in) begin
            next_r.outl  = gpx_pkg::RST_OUT;
            next_r.inv   = gpx_pkg::RST_INV;
            next_r.dir   = gpx_pkg::RST_DIR;
            next_r.dsl   = gpx_pkg::RST_DS;
            next_r.dsh   = gpx_pkg::RST_DS;
            next_r.lat   = gpx_pkg::RST_LAT;
            next_r.pen   = gpx_pkg::RST_PEN;
            next_r.psel  = gpx_pkg::RST_PSEL;
            next_r.mask  = gpx_pkg::RST_MASK;
            next_r.ostg  = gpx_pkg::RST_OSTG;
            next_r.rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk_in) begin
        r <= next_r;
    end

    assign bus.rdata = r.rdata;
    assign bus.outl  = r.outl;
    assign bus.inv   = r.inv;
    assign bus.dir   = r.dir;
    assign bus.dsl   = r.dsl;
    assign bus.dsh   = r.dsh;
    assign bus.lat   = r.lat;
    assign bus.pen   = r.pen;
    assign bus.psel  = r.psel;
    assign bus.mask  = r.mask;
    assign bus.ostg  = r.ostg;

endmodule

`default_nettype wire

/* File: rtl/gpx_expander.sv */
// Purpose: Serial-bus slave core of an 8-bit port expander.
// Assumes: Serial lines and pins are synchronous to core_clk_in.
// Notes:   Open-drain lines are split into level and active-low enable.
`timescale 1ns/1ps
`default_nettype none

module gpx_expander (
    input  wire logic        core_clk_in,         // Core clock, 25 MHz.
    input  wire logic        rst_in,              // Sync reset, high.
    input  wire logic        addr_select_bit0_in, // Address strap 0.
    input  wire logic        addr_select_bit1_in, // Address strap 1.
    input  wire logic        scl_in,              // Serial clock level.
    input  wire logic        sda_in,              // Serial data level.
    output logic             sda_out,             // Data drive level.
    output logic             sda_oe_n_out,        // Data enable, low.
    input  wire logic [7:0]  port_pin_in,         // Port pin levels.
    output logic      [7:0]  port_pin_out,        // Port drive levels.
    output logic      [7:0]  port_pin_oe_n_out,   // Port enables, low.
    output logic      [15:0] drive_code_out,      // Drive code per pin.
    output logic      [7:0]  pull_en_out,         // Pull resistor on.
    output logic      [7:0]  pull_up_sel_out,     // One pulls up.
    output logic             irq_pin_out,         // Interrupt level.
    output logic             irq_pin_oe_n_out     // Interrupt enable.
);
    typedef struct packed {
        gpx_pkg::gpx_bus_e st;
        logic              scl_d;
        logic              sda_d;
        logic [7:0]        sh;
        logic [3:0]        cnt;
        logic              rw;
        logic              acked;
        logic              sda_low;
        logic [7:0]        ptr;
        logic [7:0]        tx;
        logic              wr;
        logic [7:0]        wdata;
        logic              armed;
        logic [7:0]        snap;
        logic [7:0]        lat_v;
        logic [7:0]        lat_d;
    } gpx_core_s;

    gpx_core_s  r;
    gpx_core_s  next_r;
    gpx_reg_if  rif ();

    logic [7:0] live;
    logic [7:0] lat_act;
    logic [7:0] chg;
    logic [7:0] cap;
    logic [7:0] pend;
    logic [7:0] src;
    logic [7:0] in_val;
    logic [7:0] rd_byte;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       rd_clr;
    logic       addr_hit;

    gpx_cfg_regs u_regs (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .bus         (rif)
    );

    assign rif.wr    = r.wr;
    assign rif.ptr   = r.ptr;
    assign rif.wdata = r.wdata;

    // Bus line events, seen against the previous sample.
    assign scl_rise = scl_in & ~r.scl_d;
    assign scl_fall = ~scl_in & r.scl_d;
    assign start_c  = scl_in & r.scl_d & r.sda_d & ~sda_in;
    assign stop_c   = scl_in & r.scl_d & ~r.sda_d & sda_in;

    assign addr_hit = (r.sh[7:1] == {gpx_pkg::ADDR_FIXED,
                       addr_select_bit1_in, addr_select_bit0_in});

    // Pin sensing and change detection.
    assign live    = port_pin_in ^ rif.inv;
    assign lat_act = rif.lat & rif.dir;
    assign chg     = (live ^ r.snap) & rif.dir
                     & {8{r.armed}};
    assign cap     = lat_act & chg & ~r.lat_v;
    // A held capture stays pending even after its latch is switched off.
    assign pend    = (chg & ~lat_act) | r.lat_v;
    assign src     = pend & ~rif.mask;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            // Captured value is shown only while latching is active.
            assign in_val[gi] = (lat_act[gi] & r.lat_v[gi]) ?
                                r.lat_d[gi] : live[gi];
            // Open-drain stage releases the pin for a high level.
            assign port_pin_oe_n_out[gi] = rif.dir[gi]
                | (rif.ostg[gpx_pkg::OSTG_OD] & rif.outl[gi]);
        end
    endgenerate

    always_comb begin
        if (r.ptr == gpx_pkg::PTR_IN) begin
            rd_byte = in_val;
        end else if (r.ptr == gpx_pkg::PTR_SRC) begin
            rd_byte = src;
        end else begin
            rd_byte = rif.rdata;
        end
    end

    // Clear happens on the rising clock edge of the acknowledge bit.
    assign rd_clr = (r.st == gpx_pkg::ST_RD_ACK) & scl_rise
                    & (r.ptr == gpx_pkg::PTR_IN);

    always_comb begin
        next_r       = r;
        next_r.scl_d = scl_in;
        next_r.sda_d = sda_in;
        next_r.wr    = 1'b0;
        next_r.armed = 1'b1;
        // The reference is retaken from the live level at the clear, so a
        // change in the same cycle is neither captured nor left pending: it simply is the new level.
        if (!r.armed || rd_clr) begin
            next_r.snap = live;
        end
        next_r.lat_v = rd_clr ? 8'h00 : (r.lat_v | cap);
        next_r.lat_d = (r.lat_d & ~cap) | (live & cap);
        if (start_c) begin
            next_r.st      = gpx_pkg::ST_ADDR;
            next_r.cnt     = 4'h0;
            next_r.sda_low = 1'b0;
        end else if (stop_c) begin
            next_r.st      = gpx_pkg::ST_IDLE;
            next_r.sda_low = 1'b0;
        end else begin
            unique case (r.st)
                gpx_pkg::ST_IDLE,
                gpx_pkg::ST_WAIT: begin
                    next_r.sda_low = 1'b0;
                end
                gpx_pkg::ST_ADDR,
                gpx_pkg::ST_CMD,
                gpx_pkg::ST_WR: begin
                    if (scl_rise) begin
                        next_r.sh  = {r.sh[6:0], sda_in};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    if (scl_fall && r.cnt == gpx_pkg::BYTE_BITS) begin
                        next_r.cnt = 4'h0;
                        if (r.st == gpx_pkg::ST_ADDR) begin
                            if (addr_hit) begin
                                next_r.sda_low = 1'b1;
                                next_r.rw      = r.sh[0];
                                next_r.st      = gpx_pkg::ST_ADDR_ACK;
                            end else begin
                                next_r.st = gpx_pkg::ST_WAIT;
                            end
                        end else if (r.st == gpx_pkg::ST_CMD) begin
                            next_r.ptr     = r.sh;
                            next_r.sda_low = 1'b1;
                            next_r.st      = gpx_pkg::ST_CMD_ACK;
                        end else begin
                            next_r.wr      = 1'b1;
                            next_r.wdata   = r.sh;
                            next_r.sda_low = 1'b1;
                            next_r.st      = gpx_pkg::ST_WR_ACK;
                        end
                    end
                end
                gpx_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (r.rw) begin
                            next_r.st      = gpx_pkg::ST_RD;
                            next_r.tx      = rd_byte;
                            next_r.sda_low = ~rd_byte[7];
                        end else begin
                            next_r.st      = gpx_pkg::ST_CMD;
                            next_r.sda_low = 1'b0;
                        end
                    end
                end
                gpx_pkg::ST_CMD_ACK,
                gpx_pkg::ST_WR_ACK: begin
                    // Further bytes all land on the same pointer.
                    if (scl_fall) begin
                        next_r.sda_low = 1'b0;
                        next_r.st      = gpx_pkg::ST_WR;
                    end
                end
                gpx_pkg::ST_RD: begin
                    if (scl_rise) begin
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (r.cnt == gpx_pkg::BYTE_BITS) begin
                            next_r.cnt     = 4'h0;
                            next_r.sda_low = 1'b0;
                            next_r.st      = gpx_pkg::ST_RD_ACK;
                        end else begin
                            next_r.tx      = {r.tx[6:0], 1'b0};
                            next_r.sda_low = ~r.tx[6];
                        end
                    end
                end
                gpx_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        next_r.acked = ~sda_in;
                    end
                    if (scl_fall) begin
                        if (r.acked) begin
                            next_r.st      = gpx_pkg::ST_RD;
                            next_r.tx      = rd_byte;
                            next_r.sda_low = ~rd_byte[7];
                        end else begin
                            next_r.st = gpx_pkg::ST_WAIT;
                        end
                    end
                end
                default: begin
                    next_r.st      = gpx_pkg::ST_IDLE;
                    next_r.sda_low = 1'b0;
                end
            endcase
        end
        if (rst_in) begin
            next_r       = '0;
            next_r.st    = gpx_pkg::ST_IDLE;
            next_r.scl_d = 1'b1;
            next_r.sda_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        r <= next_r;
    end

    assign sda_out          = 1'b0;
    assign sda_oe_n_out     = ~r.sda_low;
    assign port_pin_out     = rif.outl;
    assign drive_code_out   = {rif.dsh, rif.dsl};
    assign pull_en_out      = rif.pen;
    assign pull_up_sel_out  = rif.psel;
    assign irq_pin_out      = 1'b0;
    assign irq_pin_oe_n_out = ~|src;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    a_addr_match: assert property (
        (r.st == gpx_pkg::ST_ADDR && scl_fall && r.cnt == 4'h8
         && !addr_hit && !start_c && !stop_c)
        |=> (!r.sda_low && r.st == gpx_pkg::ST_WAIT))
        else $error("acknowledged a foreign address");

    a_read_dir: assert property (
        (r.st == gpx_pkg::ST_ADDR_ACK && scl_fall && r.rw
         && !start_c && !stop_c)
        |=> (r.st == gpx_pkg::ST_RD && r.tx == $past(rd_byte)))
        else $error("read request did not start a read");

    a_cmd_pointer: assert property (
        (r.st == gpx_pkg::ST_CMD && scl_fall && r.cnt == 4'h8
         && !start_c && !stop_c)
        |=> (r.ptr == $past(r.sh) && r.sda_low))
        else $error("command byte not stored in pointer");

    a_inreg_ro: assert property (
        (rif.wr && rif.ptr == gpx_pkg::PTR_IN)
        |=> ($stable(rif.outl) && $stable(rif.dir) && $stable(rif.lat)))
        else $error("write to input register changed state");

    a_latch_hold: assert property (
        (!rd_clr) |=> ((r.lat_v & $past(r.lat_v)) == $past(r.lat_v)))
        else $error("latched capture lost before read");

    a_clear_ack: assert property (
        rd_clr |=> (r.lat_v == 8'h00 && r.snap == $past(live)))
        else $error("input read did not clear at acknowledge");

    a_mask_quiet: assert property (
        (&rif.mask) |-> irq_pin_oe_n_out)
        else $error("interrupt asserted while fully masked");

    a_out_quiet: assert property (
        (rif.dir == 8'h00 && r.lat_v == 8'h00) |-> irq_pin_oe_n_out)
        else $error("output pins raised an interrupt");

    a_input_hiz: assert property (
        (port_pin_oe_n_out & rif.dir) == rif.dir)
        else $error("input pin is being driven");

    a_reset_idle: assert property (
        @(posedge core_clk_in) disable iff (1'b0)
        rst_in |=> (r.st == gpx_pkg::ST_IDLE && sda_oe_n_out
                    && irq_pin_oe_n_out))
        else $error("reset did not idle the bus machine");

    c_write: cover property (rif.wr);
    c_read_clear: cover property (rd_clr);
    c_capture: cover property (|cap);
    c_irq: cover property (!irq_pin_oe_n_out);

endmodule

`default_nettype wire

/* File: dv/gpx_i2c_master.sv */
// Purpose: Serial bus master model with a pulled-up data line.
// Assumes: Eight core clocks per bit; lines change on falling edges.
// Notes:   A released data line reads as one.
`timescale 1ns/1ps
`default_nettype none
module gpx_i2c_master (
    input  wire logic clk_in,  // Core clock.
    input  wire logic sda_in,  // Resolved data line.
    output logic      scl_out, // Serial clock.
    output logic      sda_out  // Master data, one releases.
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_out = b;
        wt(2);
        scl_out = 1'b1;
        wt(2);
        r = sda_in;
        wt(2);
        scl_out = 1'b0;
        wt(2);
    endtask
    // A read always ends with a not-acknowledge from the master.
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                          output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(1'b1, r);
        ack = (r === 1'b0);
    endtask
    task automatic start();
        sda_out = 1'b1;
        wt(2);
        scl_out = 1'b1;
        wt(2);
        sda_out = 1'b0;
        wt(2);
        scl_out = 1'b0;
    endtask
    task automatic xfer(input logic [6:0] a, input logic rd,
                        input logic [7:0] p, input logic [7:0] wd,
                        output logic [7:0] q, output logic ack);
        logic k;
        start();
        byte_x({a, 1'b0}, q, ack);
        byte_x(p, q, k);
        if (rd) begin
            start();
            byte_x({a, 1'b1}, q, k);
            byte_x(8'hFF, q, k);
        end else begin
            byte_x(wd, q, k);
        end
        sda_out = 1'b0;
        wt(2);
        scl_out = 1'b1;
        wt(2);
        sda_out = 1'b1;
        wt(2);
    endtask
endmodule
`default_nettype wire

/* File: dv/test_gpx_expander.sv */
// Purpose: Self-checking bench for the serial port expander.
// Assumes: Pins read back the driven level where the device drives.
// Notes:   Expected values come from the register map.
`timescale 1ns/1ps
`default_nettype none
module test_gpx_expander;
    logic        core_clk_in, rst_in, a0, a1, scl, sda_m, sda_oe_n;
    logic        irq_oe_n, irq_o, sda_o, ack;
    logic [7:0]  pen_o, psel_o;
    logic [7:0]  ext, pin_o, pin_oe_n, pin_lvl, q;
    logic [15:0] dcode;
    logic        sda_w;
    int          err_total, check_count;
    assign sda_w = sda_m & (sda_oe_n | sda_o);
    assign pin_lvl = (pin_oe_n & ext) | (~pin_oe_n & pin_o);
    gpx_expander i_gpx_expander (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .addr_select_bit0_in(a0), .addr_select_bit1_in(a1), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .port_pin_in(pin_lvl), .port_pin_out(pin_o),
        .port_pin_oe_n_out(pin_oe_n), .drive_code_out(dcode),
        .pull_en_out(pen_o), .pull_up_sel_out(psel_o), .irq_pin_out(irq_o),
        .irq_pin_oe_n_out(irq_oe_n));
    gpx_i2c_master i_gpx_i2c_master (.clk_in(core_clk_in), .sda_in(sda_w),
        .scl_out(scl), .sda_out(sda_m));
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i_gpx_i2c_master.xfer({5'h1C, a1, a0}, 1'b0, p, d, q, ack);
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        i_gpx_i2c_master.xfer({5'h1C, a1, a0}, 1'b1, p, 8'h00, q, ack);
        chk("read data", {8'h00, e}, {8'h00, q});
    endtask
    // Sets the outside pin levels and judges the interrupt enable after.
    task automatic pin(input logic [7:0] v, input logic e);
        ext = v;
        wt(3);
        chk("irq line", 16'h0000 | e, 16'h0000 | (irq_oe_n | irq_o));
    endtask
    task automatic t_defaults();
        logic [7:0] pt [11] = '{8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42,
                                8'h43, 8'h44, 8'h45, 8'h46, 8'h4F};
        logic [7:0] ev [11] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00,
                                8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
        for (int i = 0; i < 11; i++) begin
            rd(pt[i], ev[i]);
        end
        chk("pin enables", 16'h00FF, {8'h00, pin_oe_n});
        chk("drive codes", 16'hFFFF, dcode);
        $display("test defaults done");
    endtask
    task automatic t_address();
        for (int s = 0; s < 4; s++) begin
            {a1, a0} = 2'(s);
            i_gpx_i2c_master.xfer({5'h1C, 2'(s)}, 1'b0, 8'h02, 8'h00, q, ack);
            chk("own address", 16'h0001, 16'h0000 | ack);
            i_gpx_i2c_master.xfer({5'h1C, 2'(s) ^ 2'h3}, 1'b0, 8'h02, 8'h55,
                                  q, ack);
            chk("other address", 16'h0000, 16'h0000 | ack);
        end
        rd(8'h02, 8'h00);
        $display("test address done");
    endtask
    task automatic t_regs();
        wr(8'h03, 8'h0F);
        wr(8'h01, 8'hA5);
        chk("pin enables", 16'h000F, {8'h00, pin_oe_n});
        chk("pin levels", 16'h00AC, {8'h00, pin_lvl});
        wr(8'h4F, 8'hFF);
        chk("open drain", 16'h00AF, {8'h00, pin_oe_n});
        rd(8'h4F, 8'h01);
        wr(8'h4F, 8'h00);
        rd(8'h01, 8'hA5);
        rd(8'h00, 8'hAC);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'hAC);
        wr(8'h02, 8'h0F);
        wr(8'h03, 8'hFF);
        rd(8'h00, 8'h33);
        wr(8'h02, 8'h00);
        wr(8'h40, 8'h1B);
        wr(8'h41, 8'hE4);
        chk("drive codes", 16'hE41B, dcode);
        wr(8'h43, 8'h5A);
        wr(8'h44, 8'h3C);
        chk("pull enables", 16'h005A, {8'h00, pen_o});
        chk("pull select", 16'h003C, {8'h00, psel_o});
        $display("test registers done");
    endtask
    task automatic t_irq();
        pin(8'h00, 1'b1);
        wr(8'h45, 8'h00);
        rd(8'h00, 8'h00);
        pin(8'h01, 1'b0);
        rd(8'h46, 8'h01);
        pin(8'h00, 1'b1);
        pin(8'h01, 1'b0);
        rd(8'h00, 8'h01);
        pin(8'h01, 1'b1);
        wr(8'h45, 8'h01);
        pin(8'h00, 1'b1);
        wr(8'h45, 8'h00);
        pin(8'h00, 1'b0);
        rd(8'h00, 8'h00);
        wr(8'h42, 8'h10);
        pin(8'h10, 1'b0);
        pin(8'h00, 1'b0);
        rd(8'h00, 8'h10);
        rd(8'h00, 8'h00);
        pin(8'h18, 1'b0);
        pin(8'h00, 1'b0);
        rd(8'h00, 8'h10);
        pin(8'h00, 1'b1);
        pin(8'h10, 1'b0);
        pin(8'h00, 1'b0);
        wr(8'h42, 8'h00);
        pin(8'h00, 1'b0);
        rd(8'h00, 8'h00);
        wr(8'h42, 8'h01);
        wr(8'h03, 8'hFE);
        wr(8'h01, 8'hA5);
        pin(8'h00, 1'b1);
        rd(8'h00, 8'h01);
        $display("test interrupts done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    initial begin
        #1500000;
        err_total++;
        test_done();
    end
    initial begin
        err_total = 0;
        check_count = 0;
        rst_in = 1'b1;
        {a1, a0} = 2'h0;
        ext = 8'h3C;
        wt(3);
        rst_in = 1'b0;
        wt(2);
        t_defaults();
        t_address();
        t_regs();
        t_irq();
        rst_in = 1'b1;
        wt(3);
        rst_in = 1'b0;
        wt(2);
        t_defaults();
        test_done();
    end
endmodule
`default_nettype wire
